/* File: src/mesb_pkg.sv */
package mesb_pkg;

  // Bus geometry: byte address, one aligned 32-bit word per register
  localparam int ADR_W = 10;
  localparam int DAT_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_ERR1 = 8'h40;
  localparam logic [7:0] IDX_ERR2 = 8'h41;
  localparam logic [7:0] IDX_ERR3 = 8'h42;
  localparam logic [7:0] IDX_ERR4 = 8'h43;
  localparam logic [7:0] IDX_SLEEP = 8'h50;
  localparam logic [7:0] IDX_OPTM1 = 8'h51;
  localparam logic [7:0] IDX_OPTM2 = 8'h52;
  localparam logic [7:0] IDX_OPTM3 = 8'h53;
  localparam logic [7:0] IDX_OPTM4 = 8'h54;
  localparam logic [7:0] IDX_CONFIG = 8'h55;
  localparam logic [7:0] IDX_STATUS = 8'h56;
  localparam logic [7:0] IDX_LIVE1 = 8'h57;
  localparam logic [7:0] IDX_LIVE2 = 8'h58;
  localparam logic [7:0] IDX_LIVE3 = 8'h59;
  localparam logic [7:0] IDX_LIVE4 = 8'h5A;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_SLEEP = 2'h0;
  localparam logic [2:0] RST_CONFIG = 3'h0;
  // Pin filter reset: the second regulator-hot pin is active low
  localparam logic [3:0] RST_PINS = 4'h2;

  // Sleep state codes
  localparam logic [1:0] SLP_S0 = 2'h0;
  localparam logic [1:0] SLP_S1 = 2'h1;
  localparam logic [1:0] SLP_S3 = 2'h2;
  localparam logic [1:0] SLP_S45 = 2'h3;

  // Configuration bit positions
  localparam int CFG_ASF_BIT = 0;
  localparam int CFG_ALERT_EN_BIT = 1;
  localparam int CFG_OLD_VID_BIT = 2;
  // Status bit position
  localparam int STS_SUMMARY_BIT = 0;

  // Pin vector positions
  localparam int PIN_REG1_HOT = 0;
  localparam int PIN_REG2_HOT_N = 1;
  localparam int PIN_FUSE_A = 2;
  localparam int PIN_FUSE_B = 3;

  // Implemented bits of the first register
  localparam logic [7:0] ERR1_VALID = 8'h3F;
  // Sleep masks: fixed (always in S3/S4-5) and optional (per mask reg)
  localparam logic [7:0] FIX_MASK1 = 8'h30;
  localparam logic [7:0] OPT_MASK1 = 8'h03;
  localparam logic [7:0] FIX_MASK2 = 8'hFF;
  localparam logic [7:0] OPT_MASK2 = 8'h00;
  localparam logic [7:0] FIX_MASK3 = 8'h47;
  localparam logic [7:0] OPT_MASK3 = 8'h38;
  localparam logic [7:0] FIX_MASK4 = 8'h3C;
  localparam logic [7:0] OPT_MASK4 = 8'hC3;

  // Condition inputs from the comparators and fault detectors
  typedef struct packed {
    logic [3:0] zone_limit;
    logic [15:0] analog_limit;
    logic diode_1a_fault;
    logic diode_1b_fault;
    logic diode_2a_fault;
    logic diode_2b_fault;
    logic [1:0] core_volt_mismatch;
  } mesb_events_s;

  // Mask applied to one register in the current sleep state
  function automatic logic [7:0] mesb_eff_mask(
    input logic [7:0] fixed,
    input logic [7:0] opt,
    input logic [7:0] opt_reg,
    input logic sleeping
  );
    mesb_eff_mask = sleeping ? (fixed | (opt & opt_reg)) : 8'h00;
  endfunction : mesb_eff_mask

endpackage : mesb_pkg

/* File: src/mesb_sticky8.sv */
`timescale 1ns/1ns
module mesb_sticky8
  import mesb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] cond_i,
  input wire logic [7:0] mask_i,
  input wire logic [7:0] clr_i,
  output logic [7:0] q_o
);

  logic [7:0] q_q;
  logic [7:0] q_d;
  logic [7:0] set_w;

  // A masked event never sets; an unmasked one sets every cycle it lasts
  assign set_w = cond_i & ~mask_i;
  // Set beats clear, so a live unmasked condition cannot be cleared
  assign q_d = set_w | (q_q & ~clr_i);
  assign q_o = q_q;

  // Sticky storage
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      q_q <= RST_BYTE;
    else
      q_q <= q_d;
  end

endmodule : mesb_sticky8

/* File: src/mesb_top.sv */
`timescale 1ns/1ns
// Overview of operation
// - Zone 1 out of limits sets bit 0
// - Zone 2 out of limits sets bit 1
// - Zones 3, 4 set bits 2, 3, unmasked
// - Regulator-hot inputs set bits 4, 5, sleep-masked
// - Analog inputs 1-8 set second register bits
// - Analog inputs 9-16 set third register bits
// - Inputs 9-11,15 masked; 12-14 optionally masked
// - Analog input 16 never masked by sleep
// - Diode 1b/1a faults set bits 0, 6
// - Diode 2b/2a faults set bits 1, 7
// - Fuse inputs set bits 2, 3, masked
// - Fuse bits enabled only in older mode
// - Core 1 voltage mismatch sets bit 4
// - Core 2 voltage mismatch sets bit 5
// - Bits sticky; clear blocked while live, unmasked
// - Read clears in ASF mode; W1C always
// - Any bit sets summary flag; alert only when enabled
// - Host sets sleep state; optional masks apply
module mesb_top
  import mesb_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic RESETN_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [ADR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [DAT_W-1:0] WB_DAT_I,
  output logic [DAT_W-1:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire mesb_events_s EVENTS_I,
  input wire logic REGULATOR1_HOT_INPUT_I,
  input wire logic REGULATOR2_HOT_INPUT_N_I,
  input wire logic FUSE_MONITOR_INPUT_A_I,
  input wire logic FUSE_MONITOR_INPUT_B_I,
  output logic SUMMARY_ERROR_FLAG_O,
  output logic ALERT_O
);

  // Bus state
  logic ack_q;
  logic [DAT_W-1:0] dat_q;

  // Software-owned control state
  logic [1:0] sleep_q;
  logic [7:0] optm1_q;
  logic [7:0] optm2_q;
  logic [7:0] optm3_q;
  logic [7:0] optm4_q;
  logic [2:0] cfg_q;

  // Derived outputs
  logic summary_q;
  logic alert_q;

  // Pin synchronisers and agreement filter
  logic [3:0] pin_raw;
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  logic [3:0] pin_s3_q;
  logic [3:0] pin_q;
  logic [3:0] pin_d;

  // Sticky error bits
  logic [7:0] err1;
  logic [7:0] err2;
  logic [7:0] err3;
  logic [7:0] err4;

  // Bus decode wires
  logic acc_w;
  logic wr_w;
  logic rd_w;
  logic [7:0] idx_w;
  logic [7:0] wbyte_w;
  logic [7:0] rbyte_w;
  logic rd_clear_w;

  // Condition, mask and clear wires
  logic sleeping_w;
  logic old_vid_w;
  logic reg1_hot_w;
  logic reg2_hot_w;
  logic [7:0] cond1_w;
  logic [7:0] cond2_w;
  logic [7:0] cond3_w;
  logic [7:0] cond4_w;
  logic [7:0] mask1_w;
  logic [7:0] mask2_w;
  logic [7:0] mask3_w;
  logic [7:0] mask4_w;
  logic [7:0] clr1_w;
  logic [7:0] clr2_w;
  logic [7:0] clr3_w;
  logic [7:0] clr4_w;
  logic any_err_w;

  // Live conditions after masking, one byte per bank
  logic [7:0] live1_w;
  logic [7:0] live2_w;
  logic [7:0] live3_w;
  logic [7:0] live4_w;

  // Wishbone access: one access per request, ack blocks a second take
  assign acc_w = WB_CYC_I & WB_STB_I & ~ack_q;
  // Only byte lane 0 carries register data; other lanes are ignored
  assign wr_w = acc_w & WB_WE_I & WB_SEL_I[0];
  assign rd_w = acc_w & ~WB_WE_I;
  assign idx_w = WB_ADR_I[9:2];
  assign wbyte_w = WB_DAT_I[7:0];

  // Pins arrive from off-chip and pass three flops
  assign pin_raw = {FUSE_MONITOR_INPUT_B_I, FUSE_MONITOR_INPUT_A_I,
                    REGULATOR2_HOT_INPUT_N_I, REGULATOR1_HOT_INPUT_I};
  // A change is taken only when the second and third stages agree
  assign pin_d = (pin_s2_q & pin_s3_q) | (pin_q & (pin_s2_q | pin_s3_q));

  // Synchroniser chain and filtered level
  // Reset to each pin's idle level so leaving reset is never an event
  always_ff @(posedge MCLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      pin_s1_q <= RST_PINS;
      pin_s2_q <= RST_PINS;
      pin_s3_q <= RST_PINS;
      pin_q <= RST_PINS;
    end
    else
    begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_q <= pin_d;
    end
  end

  assign sleeping_w = (sleep_q == SLP_S3) || (sleep_q == SLP_S45);
  assign old_vid_w = cfg_q[CFG_OLD_VID_BIT];
  assign reg1_hot_w = pin_q[PIN_REG1_HOT];
  // Second regulator-hot pin is active low
  assign reg2_hot_w = ~pin_q[PIN_REG2_HOT_N];

  // zones 3 and 4 into bits 2, 3
  // regulator-hot events into bits 4, 5
  assign cond1_w = {2'b00, reg2_hot_w, reg1_hot_w, EVENTS_I.zone_limit}
                   & ERR1_VALID;
  assign cond2_w = EVENTS_I.analog_limit[7:0];
  assign cond3_w = EVENTS_I.analog_limit[15:8];
  // diode 1b bit 0, diode 1a bit 6
  // diode 2b bit 1, diode 2a bit 7
  // fuse inputs into bits 2, 3
  // fuse bits gated by older mode
  assign cond4_w = {EVENTS_I.diode_2a_fault,
                    EVENTS_I.diode_1a_fault,
                    EVENTS_I.core_volt_mismatch[1],
                    EVENTS_I.core_volt_mismatch[0],
                    pin_q[PIN_FUSE_B] & old_vid_w,
                    pin_q[PIN_FUSE_A] & old_vid_w,
                    EVENTS_I.diode_2b_fault,
                    EVENTS_I.diode_1b_fault};

  // optional masks only touch optional bits
  // zone 3 and 4 bits absent from both masks
  // bit 7 of the third register in neither mask
  assign mask1_w = mesb_eff_mask(FIX_MASK1, OPT_MASK1, optm1_q, sleeping_w);
  assign mask2_w = mesb_eff_mask(FIX_MASK2, OPT_MASK2, optm2_q, sleeping_w);
  assign mask3_w = mesb_eff_mask(FIX_MASK3, OPT_MASK3, optm3_q, sleeping_w);
  assign mask4_w = mesb_eff_mask(FIX_MASK4, OPT_MASK4, optm4_q, sleeping_w);

  // Live view: what would set each bank at the next edge
  assign live1_w = cond1_w & ~mask1_w;
  assign live2_w = cond2_w & ~mask2_w;
  assign live3_w = cond3_w & ~mask3_w;
  assign live4_w = cond4_w & ~mask4_w;

  // Clear pattern for one sticky bank: write-one offers the written bits,
  // a read-clear offers all eight. The bank's own set logic still keeps a
  // bit whose condition is live and unmasked, so no event is lost here.
  function automatic logic [7:0] clr_bits(
    input logic [7:0] own_idx,
    input logic [7:0] idx,
    input logic wr,
    input logic rd_clr,
    input logic [7:0] wbyte
  );
    logic hit;
    hit = (idx == own_idx);
    clr_bits = ({8{hit & wr}} & wbyte) | {8{hit & rd_clr}};
  endfunction : clr_bits

  // read clears only in ASF mode; write-one always clears
  assign rd_clear_w = rd_w & cfg_q[CFG_ASF_BIT];
  assign clr1_w = clr_bits(IDX_ERR1, idx_w, wr_w, rd_clear_w, wbyte_w);
  assign clr2_w = clr_bits(IDX_ERR2, idx_w, wr_w, rd_clear_w, wbyte_w);
  assign clr3_w = clr_bits(IDX_ERR3, idx_w, wr_w, rd_clear_w, wbyte_w);
  assign clr4_w = clr_bits(IDX_ERR4, idx_w, wr_w, rd_clear_w, wbyte_w);

  // sticky bits, clear refused while live and unmasked
  // set has priority over clear inside each bank
  mesb_sticky8 u_err1 (
    .clk_i(MCLK_I),
    .rst_n_i(RESETN_I),
    .cond_i(cond1_w),
    .mask_i(mask1_w),
    .clr_i(clr1_w),
    .q_o(err1)
  );

  mesb_sticky8 u_err2 (
    .clk_i(MCLK_I),
    .rst_n_i(RESETN_I),
    .cond_i(cond2_w),
    .mask_i(mask2_w),
    .clr_i(clr2_w),
    .q_o(err2)
  );

  mesb_sticky8 u_err3 (
    .clk_i(MCLK_I),
    .rst_n_i(RESETN_I),
    .cond_i(cond3_w),
    .mask_i(mask3_w),
    .clr_i(clr3_w),
    .q_o(err3)
  );

  mesb_sticky8 u_err4 (
    .clk_i(MCLK_I),
    .rst_n_i(RESETN_I),
    .cond_i(cond4_w),
    .mask_i(mask4_w),
    .clr_i(clr4_w),
    .q_o(err4)
  );

  // Read selection; data is the value before any read-clear lands
  // The live view lets software tell a stale bit from a present condition
  // reserved bits of the first register read as zero
  assign rbyte_w =
    (idx_w == IDX_ERR1)   ? (err1 & ERR1_VALID) :
    (idx_w == IDX_ERR2)   ? err2 :
    (idx_w == IDX_ERR3)   ? err3 :
    (idx_w == IDX_ERR4)   ? err4 :
    (idx_w == IDX_SLEEP)  ? {6'h00, sleep_q} :
    (idx_w == IDX_OPTM1)  ? (optm1_q & OPT_MASK1) :
    (idx_w == IDX_OPTM2)  ? (optm2_q & OPT_MASK2) :
    (idx_w == IDX_OPTM3)  ? (optm3_q & OPT_MASK3) :
    (idx_w == IDX_OPTM4)  ? (optm4_q & OPT_MASK4) :
    (idx_w == IDX_CONFIG) ? {5'h00, cfg_q} :
    (idx_w == IDX_STATUS) ? {7'h00, summary_q} :
    (idx_w == IDX_LIVE1)  ? live1_w :
    (idx_w == IDX_LIVE2)  ? live2_w :
    (idx_w == IDX_LIVE3)  ? live3_w :
    (idx_w == IDX_LIVE4)  ? live4_w :
    8'h00;

  // Ack one cycle after the request; unmapped words still ack with zero
  always_ff @(posedge MCLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end
    else
    begin
      ack_q <= acc_w;
      if (rd_w)
        dat_q <= {24'h000000, rbyte_w};
    end
  end

  // host writes sleep state and optional mask registers
  // Only optional bits are stored, so software can never lift a fixed
  // sleep mask; the fixed ones are wired from package constants
  always_ff @(posedge MCLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      sleep_q <= RST_SLEEP;
      optm1_q <= RST_BYTE;
      optm2_q <= RST_BYTE;
      optm3_q <= RST_BYTE;
      optm4_q <= RST_BYTE;
      cfg_q <= RST_CONFIG;
    end
    else if (wr_w)
    begin
      if (idx_w == IDX_SLEEP)
        sleep_q <= wbyte_w[1:0];
      if (idx_w == IDX_OPTM1)
        optm1_q <= wbyte_w & OPT_MASK1;
      if (idx_w == IDX_OPTM2)
        optm2_q <= wbyte_w & OPT_MASK2;
      if (idx_w == IDX_OPTM3)
        optm3_q <= wbyte_w & OPT_MASK3;
      if (idx_w == IDX_OPTM4)
        optm4_q <= wbyte_w & OPT_MASK4;
      if (idx_w == IDX_CONFIG)
        cfg_q <= wbyte_w[2:0];
    end
  end

  // any sticky bit raises the summary flag
  assign any_err_w = |{err1, err2, err3, err4};

  // Summary and alert are registered so the pins never glitch
  // Limitation: both lag the sticky bits by one cycle
  always_ff @(posedge MCLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      summary_q <= 1'b0;
      alert_q <= 1'b0;
    end
    else
    begin
      summary_q <= any_err_w;
      // alert follows the flag when enabled
      alert_q <= any_err_w & cfg_q[CFG_ALERT_EN_BIT];
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = dat_q;
  assign SUMMARY_ERROR_FLAG_O = summary_q;
  assign ALERT_O = alert_q;

endmodule : mesb_top

/* File: tb/mesb_err_properties.sv */
`timescale 1ns/1ns
module mesb_err_properties
  import mesb_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic RESETN_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [ADR_W-1:0] WB_ADR_I,
  input wire logic [DAT_W-1:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire mesb_events_s EVENTS_I,
  input wire logic SUMMARY_ERROR_FLAG_O,
  input wire logic ALERT_O
);
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RESETN_I);
  // A request is taken only while no answer is standing
  wire logic take;
  wire logic rd_err1;
  assign take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign rd_err1 = take && !WB_WE_I && WB_ADR_I[9:2] == IDX_ERR1;

  property p_ack_one;
    WB_ACK_O |=> !WB_ACK_O;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one");
  property p_ack_next;
    take |=> WB_ACK_O;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  property p_zone3;
    EVENTS_I.zone_limit[2] |-> ##2 SUMMARY_ERROR_FLAG_O;
  endproperty
  a_zone3: assert property (p_zone3) else $error("zone 3 lost");
  property p_adin16;
    EVENTS_I.analog_limit[15] |-> ##2 SUMMARY_ERROR_FLAG_O;
  endproperty
  a_adin16: assert property (p_adin16) else $error("input 16 lost");
  property p_alert;
    ALERT_O |-> SUMMARY_ERROR_FLAG_O;
  endproperty
  a_alert: assert property (p_alert) else $error("alert alone");
  property p_res_zero;
    rd_err1 |=> WB_DAT_O[7:6] == 2'h0;
  endproperty
  a_res_zero: assert property (p_res_zero) else $error("bits 7:6 set");
  property p_upper_zero;
    WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper data set");
  property p_sticky;
    $fell(SUMMARY_ERROR_FLAG_O) |-> $past(take, 2);
  endproperty
  a_sticky: assert property (p_sticky) else $error("bit fell alone");
endmodule : mesb_err_properties

bind mesb_top mesb_err_properties u_chk (
  .MCLK_I(MCLK_I),
  .RESETN_I(RESETN_I),
  .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I),
  .WB_ADR_I(WB_ADR_I),
  .WB_DAT_O(WB_DAT_O),
  .WB_ACK_O(WB_ACK_O),
  .EVENTS_I(EVENTS_I),
  .SUMMARY_ERROR_FLAG_O(SUMMARY_ERROR_FLAG_O),
  .ALERT_O(ALERT_O)
);

/* File: tb/mesb_host_model.sv */
`timescale 1ns/1ns
module mesb_host_model
  import mesb_pkg::*;
(
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [DAT_W-1:0] dat_i,
  output logic cyc_o,
  output logic we_o,
  output logic [3:0] sel_o,
  output logic [ADR_W-1:0] adr_o,
  output logic [DAT_W-1:0] dat_o
);
  // Idle bus at time zero
  initial
  begin
    cyc_o = 1'h0;
    we_o = 1'h0;
    sel_o = 4'h0;
    adr_o = '0;
    dat_o = '0;
  end

  // sleep state and masks go out as plain transfers
  task automatic xfer(input logic w, input logic [7:0] idx,
    input logic [7:0] wd, output logic [7:0] rd, output bit ok);
    int n;
    @(posedge clk_i);
    cyc_o <= 1'h1;
    we_o <= w;
    sel_o <= 4'hF;
    adr_o <= {idx, 2'h0};
    dat_o <= {24'h0, wd};
    ok = 1'h0;
    for (n = 0; n < 20 && !ok; n++)
    begin
      @(posedge clk_i);
      ok = ack_i;
    end
    rd = dat_i[7:0];
    cyc_o <= 1'h0;
    sel_o <= 4'h0;
    // Released data flips so a stale value is never mistaken
    dat_o <= ~dat_o;
  endtask : xfer
endmodule : mesb_host_model

/* File: tb/testbench.sv */
`timescale 1ns/1ns
module testbench
  import mesb_pkg::*;
;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic cyc, we, ack, summ, alert;
  logic [3:0] sel;
  logic [ADR_W-1:0] adr;
  logic [DAT_W-1:0] wdat, rdat;
  mesb_events_s ev = '0;
  logic reg1 = 1'h0;
  logic reg2_n = 1'h1;
  logic fa = 1'h0;
  logic fb = 1'h0;
  int n_mismatch = 0;
  int cmp_count = 0;

  // 250 MHz
  always #2 clk = ~clk;

  mesb_host_model host (.clk_i(clk), .ack_i(ack), .dat_i(rdat),
    .cyc_o(cyc), .we_o(we), .sel_o(sel), .adr_o(adr), .dat_o(wdat));
  mesb_top dut (.MCLK_I(clk), .RESETN_I(rst_n), .WB_CYC_I(cyc),
    .WB_STB_I(cyc), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .EVENTS_I(ev),
    .REGULATOR1_HOT_INPUT_I(reg1), .REGULATOR2_HOT_INPUT_N_I(reg2_n),
    .FUSE_MONITOR_INPUT_A_I(fa), .FUSE_MONITOR_INPUT_B_I(fb),
    .SUMMARY_ERROR_FLAG_O(summ), .ALERT_O(alert));

  task automatic report_and_stop();
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Bus access; a lost answer ends the run
  task automatic bus(input logic w, input logic [7:0] i,
    input logic [7:0] d, output logic [7:0] r);
    bit ok;
    host.xfer(w, i, d, r, ok);
    if (!ok)
    begin
      n_mismatch++;
      report_and_stop();
    end
  endtask : bus

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [7:0] r;
    bus(1'h1, i, d, r);
  endtask : wr

  task automatic rdchk(input logic [7:0] i, input logic [7:0] e);
    logic [7:0] r;
    bus(1'h0, i, 8'h00, r);
    chk(r, e);
  endtask : rdchk

  task automatic s_reset();
    for (int i = 0; i < 4; i++)
      rdchk(IDX_ERR1 + 8'(i), RST_BYTE);
    rdchk(8'h7F, 8'h00); // unmapped place reads zero
  endtask : s_reset

  task automatic s_sticky();
    ev.zone_limit <= 4'hC;
    @(posedge clk);
    ev.zone_limit <= 4'h0;
    rdchk(IDX_ERR1, 8'h0C);
    rdchk(IDX_ERR1, 8'h0C);
    rdchk(IDX_STATUS, 8'h01);
    chk({7'h00, summ}, 8'h01);
    chk({7'h00, alert}, 8'h00);
    wr(IDX_ERR1, 8'hC0);
    rdchk(IDX_ERR1, 8'h0C);
    wr(IDX_ERR1, 8'hFF);
    rdchk(IDX_ERR1, 8'h00);
    rdchk(IDX_STATUS, 8'h00);
  endtask : s_sticky

  task automatic s_sleep();
    wr(IDX_OPTM1, 8'h01);
    ev.zone_limit <= 4'h3;
    wr(IDX_SLEEP, {6'h0, SLP_S3});
    ev.analog_limit <= 16'h8101;
    wr(IDX_ERR1, 8'hFF);
    wr(IDX_ERR3, 8'hFF);
    rdchk(IDX_ERR3, 8'h80);
    rdchk(IDX_ERR2, 8'h00);
    rdchk(IDX_ERR1, 8'h02);
    ev <= '0;
    wr(IDX_SLEEP, {6'h0, SLP_S0});
    ev.analog_limit <= 16'h0001;
    @(posedge clk);
    ev.analog_limit <= 16'h0000;
    rdchk(IDX_ERR2, 8'h01);
    wr(IDX_ERR1, 8'hFF);
    wr(IDX_ERR2, 8'hFF);
    wr(IDX_ERR3, 8'hFF);
  endtask : s_sleep

  task automatic s_asf();
    wr(IDX_CONFIG, 8'h03);
    ev <= {4'h0, 16'h0000, 4'hF, 2'h3};
    @(posedge clk);
    ev <= '0;
    repeat (2) @(posedge clk);
    chk({7'h00, alert}, 8'h01);
    rdchk(IDX_ERR4, 8'hF3);
    rdchk(IDX_ERR4, 8'h00);
    wr(IDX_CONFIG, 8'h00);
  endtask : s_asf

  task automatic s_masks();
    wr(IDX_SLEEP, {6'h0, SLP_S45});
    wr(IDX_OPTM3, 8'h10);
    wr(IDX_OPTM4, 8'h41);
    rdchk(IDX_OPTM3, 8'h10);
    ev <= {4'h0, 16'hFF00, 4'hF, 2'h3};
    rdchk(IDX_LIVE3, 8'hA8);
    rdchk(IDX_LIVE4, 8'h82);
    rdchk(IDX_ERR4, 8'h82);
    ev <= '0;
    wr(IDX_SLEEP, {6'h0, SLP_S0});
    wr(IDX_ERR3, 8'hFF);
    wr(IDX_ERR4, 8'hFF);
    rdchk(IDX_ERR3, 8'h00);
  endtask : s_masks

  task automatic s_pins();
    wr(IDX_SLEEP, {6'h0, SLP_S3});
    reg1 <= 1'h1;
    reg2_n <= 1'h0;
    fa <= 1'h1;
    fb <= 1'h1;
    repeat (8) @(posedge clk);
    rdchk(IDX_ERR1, 8'h00);
    wr(IDX_SLEEP, {6'h0, SLP_S0});
    rdchk(IDX_ERR1, 8'h30);
    rdchk(IDX_ERR4, 8'h00);
    wr(IDX_CONFIG, 8'h04);
    rdchk(IDX_ERR4, 8'h0C);
  endtask : s_pins

  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    s_reset();
    s_sticky();
    s_sleep();
    s_asf();
    s_masks();
    s_pins();
    report_and_stop();
  end
endmodule : testbench
